// File: bench/rdr_cfg_host.sv
// Configuration host model: byte reads and writes on the register port.
// Assumes the block takes requests on the rising edge; this model moves at the falling edge.
`timescale 1ns/1ps
module rdr_cfg_host
   import rdr_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output rdr_req_s regReq,
   input wire logic [7:0] regRdData
);
   initial regReq = '0;

   // Idle fields flip so a stale address or data never looks valid
   task automatic idle();
      regReq.wrEn = 1'b0;
      regReq.rdEn = 1'b0;
      regReq.addr = ~regReq.addr;
      regReq.data = ~regReq.data;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq.addr = a;
      regReq.data = d;
      regReq.wrEn = 1'b1;
      @(negedge clk);
      idle();
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regReq.addr = a;
      regReq.rdEn = 1'b1;
      @(negedge clk);
      d = regRdData;
      idle();
   endtask
endmodule

// File: bench/rdr_regs_tb_top.sv
// Testbench for the redriver EQ, detect control and port status registers.
// Assumes the package, design files and the host model are compiled first.
`timescale 1ns/1ps
module rdr_regs_tb_top
   import rdr_pkg::*;
();
   // Short millisecond keeps the detect periods to a few hundred cycles
   localparam int CPM = 2;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   rdr_req_s regReq;
   logic [7:0] regRdData;
   logic [1:0] straps = 2'h2;
   logic takeover = 1'b0;
   logic aeqEn = 1'b0;
   logic [1:0] aeqMethod = 2'h2;
   rdr_link_s [NUM_PORTS-1:0] link = {7'h10, 7'h10};
   logic [EQ_W-1:0] rx1Eq;
   logic [EQ_W-1:0] rx2Eq;
   logic termOff;
   logic lpOff;
   logic compOff;
   logic [NUM_PORTS-1:0] skipDet;
   logic [NUM_PORTS-1:0] detPulse;
   int errCount = 0;
   int checks = 0;
   // Rows: written byte, then expected {termination off, sleep detect off, compliance off}
   logic [10:0] miscRows [5] = '{11'h404, 11'h082, 11'h009, 11'h48f, 11'h020};

   always #2 clk = ~clk;

   rdr_regs #(.CyclesPerMs(CPM)) dut (
      .clk(clk),
      .rst_n(rst_n),
      .regReq(regReq),
      .regRdData(regRdData),
      .hostEqStrapPins(straps),
      .eqSoftwareTakeover(takeover),
      .adaptiveEqEnable(aeqEn),
      .adaptiveEqMethod(aeqMethod),
      .link(link),
      .hostRx1Eq(rx1Eq),
      .hostRx2Eq(rx2Eq),
      .termOffAtDetect(termOff),
      .lowPowerDetectOff(lpOff),
      .complianceDetectOff(compOff),
      .skipDetect(skipDet),
      .detectPulse(detPulse)
   );

   rdr_cfg_host host (
      .clk(clk),
      .regReq(regReq),
      .regRdData(regRdData)
   );

   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         errCount++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic stopTest();
      $display("checks %0d mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      chk($sformatf("register %h", a), v, exp);
   endtask

   // Cycles until the next port one detect tick, 0 if none within the bound
   task automatic gap(input int bound, output int n);
      n = 0;
      for (int i = 1; i <= bound && n == 0; i++) begin
         @(negedge clk);
         if (detPulse[0] === 1'b1) begin
            n = i;
         end
      end
   endtask

   // First gap has an unknown phase; the second is the true period
   task automatic detCase(input logic [7:0] m, input logic sl, input int exp);
      int n;
      host.wr(ADDR_MISC, m);
      link[0].inSleep = sl;
      link[0].inUnplugged = ~sl;
      gap(400, n);
      gap(400, n);
      chk("detect period", n, exp);
      if (n == 0 && exp != 0) begin
         stopTest();
      end
   endtask

   initial begin
      repeat (5) @(negedge clk);
      chk("reset outputs", {regRdData, rx1Eq, rx2Eq, termOff, lpOff, compOff, skipDet,
         detPulse}, 24'h0);
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      // Strap capture needs three edges after release
      repeat (6) @(negedge clk);
      rdChk(ADDR_HOST_EQ, {2'h0, straps, 2'h0, straps});
      chk("strap eq", {rx2Eq, rx1Eq}, {2'h0, straps, 2'h0, straps});
      rdChk(ADDR_MISC, RST_MISC);
      rdChk(ADDR_STAT1, RST_STAT);
      rdChk(ADDR_STAT2, RST_STAT);
      rdChk(8'h23, READ_UNMAPPED);
      $display("test reset done");

      foreach (miscRows[i]) begin
         host.wr(ADDR_MISC, miscRows[i][10:3]);
         rdChk(ADDR_MISC, miscRows[i][10:3]);
         chk("misc outputs", {termOff, lpOff, compOff}, miscRows[i][2:0]);
      end
      $display("test misc table done");

      host.wr(ADDR_HOST_EQ, 8'h5a);
      rdChk(ADDR_HOST_EQ, {2'h0, straps, 2'h0, straps});
      takeover = 1'b1;
      host.wr(ADDR_HOST_EQ, 8'ha5);
      rdChk(ADDR_HOST_EQ, 8'ha5);
      chk("host eq", {rx2Eq, rx1Eq}, 8'ha5);
      $display("test takeover done");

      link[0] = 7'h40;
      link[1] = 7'h2c;
      aeqEn = 1'b1;
      host.wr(ADDR_STAT1, 8'hff);
      rdChk(ADDR_STAT1, 8'h04);
      rdChk(ADDR_STAT2, 8'h1a);
      link[0].longChannel = 1'b1;
      repeat (2) @(negedge clk);
      rdChk(ADDR_STAT1, 8'h84);
      aeqMethod = 2'h1;
      repeat (2) @(negedge clk);
      rdChk(ADDR_STAT1, 8'h04);
      aeqMethod = 2'h2;
      aeqEn = 1'b0;
      repeat (2) @(negedge clk);
      rdChk(ADDR_STAT1, 8'h04);
      link[0] = 7'h10;
      repeat (2) @(negedge clk);
      rdChk(ADDR_STAT1, 8'h01);
      link[1] = 7'h10;
      repeat (2) @(negedge clk);
      rdChk(ADDR_STAT2, 8'h01);
      $display("test status done");

      host.wr(ADDR_MISC, 8'h02);
      link[0].warmPollSeen = 1'b1;
      repeat (2) @(negedge clk);
      chk("skip detect", skipDet, 2'h1);
      link[1].warmPollSeen = 1'b1;
      repeat (2) @(negedge clk);
      chk("skip detect both", skipDet, 2'h3);
      host.wr(ADDR_MISC, 8'h00);
      repeat (2) @(negedge clk);
      chk("skip detect off", skipDet, 2'h0);
      link[0].warmPollSeen = 1'b0;
      link[1].warmPollSeen = 1'b0;
      $display("test warm skip done");

      detCase(8'h00, 1'b0, DS_PERIOD_MS[0] * CPM);
      detCase(8'h0c, 1'b0, DS_PERIOD_MS[3] * CPM);
      detCase(8'h00, 1'b1, LP_PERIOD_MS[0] * CPM);
      detCase(8'h4c, 1'b1, LP_PERIOD_MS[2] * CPM);
      detCase(8'h10, 1'b1, 0);
      $display("test detect done");
      stopTest();
   end
endmodule

// File: common/rdr_pkg.sv
// Shared constants and carrier types for the redriver EQ, detect and status registers.
// Assumes a single 250 MHz clock domain for all users of this package.
package rdr_pkg;
   localparam int CLK_MHZ = 250;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int NUM_PORTS = 2;
   localparam int EQ_W = 4;

   // Register offsets and reset values
   localparam logic [7:0] ADDR_HOST_EQ = 8'h21;
   localparam logic [7:0] ADDR_MISC = 8'h22;
   localparam logic [7:0] ADDR_STAT1 = 8'h24;
   localparam logic [7:0] ADDR_STAT2 = 8'h25;
   localparam logic [7:0] RST_HOST_EQ = 8'h00;
   localparam logic [7:0] RST_MISC = 8'h04;
   localparam logic [7:0] RST_STAT = 8'h01;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam logic [1:0] STRAP_PAD = 2'h0;

   // Power-state flags {active, sleep, unplugged}
   localparam logic [2:0] PWR_FLAGS_RST = 3'h1;
   localparam logic [2:0] PWR_FLAGS_CLR = 3'h0;

   // Detect periods in ms, indexed by field code
   localparam int LP_PERIOD_MS [4] = '{48, 84, 120, 156};
   localparam int DS_PERIOD_MS [4] = '{4, 6, 36, 84};

   // Host-side EQ register layout
   typedef struct packed {
      logic [EQ_W-1:0] rx2;
      logic [EQ_W-1:0] rx1;
   } rdr_host_eq_s;

   // Misc register layout
   typedef struct packed {
      logic termOffAtStart;
      logic [1:0] lowPowerPeriod;
      logic lowPowerOff;
      logic [1:0] downstreamPeriod;
      logic skipAfterWarm;
      logic complianceOff;
   } rdr_misc_s;

   // Port status register layout
   typedef struct packed {
      logic longChannel;
      logic [1:0] rsvd;
      logic dualLane;
      logic compliance;
      logic activeState;
      logic sleepState;
      logic unplugged;
   } rdr_stat_s;

   // Level indications from one port's link state machine
   typedef struct packed {
      logic inU0;
      logic inSleep;
      logic inUnplugged;
      logic inCompliance;
      logic dualLane;
      logic longChannel;
      logic warmPollSeen;
   } rdr_link_s;

   // Register access request from the control interface
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic wrEn;
      logic rdEn;
   } rdr_req_s;
endpackage

// File: rtl/rdr_detect_timer.sv
// Periodic receiver-detect tick for one downstream port.
// Assumes link levels on the same clock; period follows the misc fields live.
`timescale 1ns/1ps
module rdr_detect_timer
   import rdr_pkg::*;
#(
   parameter int CyclesPerMs = CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Controls
   input rdr_misc_s misc,
   input wire logic inSleep,
   input wire logic inUnplugged,
   // Tick
   output logic detectPulse
);
   logic run;
   logic [31:0] limit;
   logic [31:0] cnt_q;

   always_comb begin
      run = inUnplugged | (inSleep & ~misc.lowPowerOff);
      if (inSleep) begin
         limit = 32'(LP_PERIOD_MS[misc.lowPowerPeriod] * CyclesPerMs);
      end else begin
         limit = 32'(DS_PERIOD_MS[misc.downstreamPeriod] * CyclesPerMs);
      end
   end

   // Counter restarts whenever detection is not wanted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h0;
         detectPulse <= 1'b0;
      end else if (!run) begin
         cnt_q <= 32'h0;
         detectPulse <= 1'b0;
      end else if (cnt_q >= limit - 32'h1) begin
         cnt_q <= 32'h0;
         detectPulse <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         detectPulse <= 1'b0;
      end
   end
endmodule

// File: rtl/rdr_port_status.sv
// One port's link status flags, all held in flops.
// Assumes link indications come from logic on the same clock.
`timescale 1ns/1ps
module rdr_port_status
   import rdr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link state machine and fast adaptive EQ qualifier
   input rdr_link_s link,
   input wire logic aeqFast,
   // Status
   output rdr_stat_s stat
);
   logic [2:0] lvl;
   logic [2:0] prev_q;
   logic [2:0] flag_q;
   logic longCh_q;
   logic dual_q;
   logic cmpl_q;

   assign lvl = {link.inU0, link.inSleep, link.inUnplugged};

   // Entry sets, leaving clears; set terms win over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= PWR_FLAGS_RST;
         flag_q <= PWR_FLAGS_RST;
      end else begin
         prev_q <= lvl;
         flag_q <= (flag_q & ~(prev_q & ~lvl)) | (lvl & ~prev_q);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         longCh_q <= 1'b0;
         dual_q <= 1'b0;
         cmpl_q <= 1'b0;
      end else begin
         longCh_q <= aeqFast & link.longChannel;
         dual_q <= link.dualLane;
         cmpl_q <= link.inCompliance;
      end
   end

   assign stat = '{longChannel: longCh_q, rsvd: 2'h0, dualLane: dual_q, compliance: cmpl_q,
                   activeState: flag_q[2], sleepState: flag_q[1], unplugged: flag_q[0]};

   a_active_entry: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(link.inU0) |=> stat.activeState)
      else $error("active flag not set on entry");
   a_leave_clears: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(link.inSleep) |=> !stat.sleepState)
      else $error("sleep flag kept after exit");
endmodule

// File: rtl/rdr_regs.sv
// Host-side EQ, detect control and port status registers of the redriver.
// Assumes a same-clock register port behind the control interface; straps are async pins.
`timescale 1ns/1ps
module rdr_regs
   import rdr_pkg::*;
#(
   parameter int CyclesPerMs = CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input rdr_req_s regReq,
   output logic [7:0] regRdData,
   // Strap pins and loose control bits
   input wire logic [1:0] hostEqStrapPins,
   input wire logic eqSoftwareTakeover,
   input wire logic adaptiveEqEnable,
   input wire logic [1:0] adaptiveEqMethod,
   // Link state machines
   input rdr_link_s [NUM_PORTS-1:0] link,
   // Receiver EQ
   output logic [EQ_W-1:0] hostRx1Eq,
   output logic [EQ_W-1:0] hostRx2Eq,
   // Detect controls
   output logic termOffAtDetect,
   output logic lowPowerDetectOff,
   output logic complianceDetectOff,
   output logic [NUM_PORTS-1:0] skipDetect,
   output logic [NUM_PORTS-1:0] detectPulse
);
   logic [1:0] strapMeta_q;
   logic [1:0] strapSync_q;
   logic [1:0] strapEq_q;
   logic strapCaught_q;
   logic [1:0] strapWarm_q;
   rdr_host_eq_s hostEq_q;
   rdr_host_eq_s strapView;
   rdr_misc_s misc_q;
   rdr_stat_s [NUM_PORTS-1:0] portStat;
   logic aeqFast;
   logic [7:0] rdNext;
   logic wrHostEq;
   logic wrMisc;

   // Strap synchroniser; only the second stage is read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta_q <= 2'h0;
         strapSync_q <= 2'h0;
      end else begin
         strapMeta_q <= hostEqStrapPins;
         strapSync_q <= strapMeta_q;
      end
   end

   // Synchroniser needs two edges to fill before its output means anything
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapWarm_q <= 2'h0;
      end else begin
         strapWarm_q <= {strapWarm_q[0], 1'b1};
      end
   end

   // Straps caught once after reset release, past the synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapEq_q <= 2'h0;
         strapCaught_q <= 1'b0;
      end else if (!strapCaught_q && strapWarm_q[1]) begin
         strapEq_q <= strapSync_q;
         strapCaught_q <= 1'b1;
      end
   end

   // Two pins give only the four lowest settings on each receiver
   assign strapView = '{rx2: {STRAP_PAD, strapEq_q}, rx1: {STRAP_PAD, strapEq_q}};

   assign wrHostEq = regReq.wrEn && (regReq.addr == ADDR_HOST_EQ);
   assign wrMisc = regReq.wrEn && (regReq.addr == ADDR_MISC);

   // Host EQ tracks the straps until software takes over
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostEq_q <= RST_HOST_EQ;
      end else if (!eqSoftwareTakeover) begin
         hostEq_q <= strapView;
      end else if (wrHostEq) begin
         hostEq_q <= regReq.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostRx1Eq <= RST_HOST_EQ[EQ_W-1:0];
         hostRx2Eq <= RST_HOST_EQ[2*EQ_W-1:EQ_W];
      end else begin
         hostRx1Eq <= hostEq_q.rx1;
         hostRx2Eq <= hostEq_q.rx2;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         misc_q <= RST_MISC;
      end else if (wrMisc) begin
         misc_q <= regReq.data;
      end
   end

   assign termOffAtDetect = misc_q.termOffAtStart;
   assign lowPowerDetectOff = misc_q.lowPowerOff;
   assign complianceDetectOff = misc_q.complianceOff;

   // Fast method is any code with bit 0 clear
   assign aeqFast = adaptiveEqEnable & ~adaptiveEqMethod[0];

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      rdr_port_status u_stat (
         .clk(clk),
         .rst_n(rst_n),
         .link(link[p]),
         .aeqFast(aeqFast),
         .stat(portStat[p])
      );
      rdr_detect_timer #(
         .CyclesPerMs(CyclesPerMs)
      ) u_tmr (
         .clk(clk),
         .rst_n(rst_n),
         .misc(misc_q),
         .inSleep(link[p].inSleep),
         .inUnplugged(link[p].inUnplugged),
         .detectPulse(detectPulse[p])
      );
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            skipDetect[p] <= 1'b0;
         end else begin
            skipDetect[p] <= misc_q.skipAfterWarm & link[p].warmPollSeen;
         end
      end
   end

   // Read decode
   always_comb begin
      if (regReq.addr == ADDR_HOST_EQ) begin
         rdNext = hostEq_q;
      end else if (regReq.addr == ADDR_MISC) begin
         rdNext = misc_q;
      end else if (regReq.addr == ADDR_STAT1) begin
         rdNext = portStat[0];
      end else if (regReq.addr == ADDR_STAT2) begin
         rdNext = portStat[1];
      end else begin
         rdNext = READ_UNMAPPED;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= READ_UNMAPPED;
      end else if (regReq.rdEn) begin
         regRdData <= rdNext;
      end
   end

   // Checks
   a_rx2_write: assert property (@(posedge clk) disable iff (!rst_n)
      wrHostEq && eqSoftwareTakeover ##1 eqSoftwareTakeover
      |=> hostRx2Eq == $past(regReq.data[7:4], 2))
      else $error("rx2 EQ not applied from write");

   a_rx1_write: assert property (@(posedge clk) disable iff (!rst_n)
      wrHostEq && eqSoftwareTakeover ##1 eqSoftwareTakeover
      |=> hostRx1Eq == $past(regReq.data[3:0], 2))
      else $error("rx1 EQ not applied from write");

   a_strap_readback: assert property (@(posedge clk) disable iff (!rst_n)
      strapCaught_q && !eqSoftwareTakeover
      |=> hostEq_q == strapView)
      else $error("EQ field does not reflect straps");

   a_hosteq_read: assert property (@(posedge clk) disable iff (!rst_n)
      regReq.rdEn && regReq.addr == ADDR_HOST_EQ
      |=> regRdData == $past(hostEq_q))
      else $error("host EQ read wrong");

   a_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      strapCaught_q && wrHostEq && !eqSoftwareTakeover
      |=> hostEq_q.rx1 == {STRAP_PAD, strapEq_q})
      else $error("EQ write taken without takeover");

   a_hold_takeover: assert property (@(posedge clk) disable iff (!rst_n)
      eqSoftwareTakeover && !wrHostEq
      |=> $stable(hostEq_q))
      else $error("host EQ moved without a write");

   a_misc_write: assert property (@(posedge clk) disable iff (!rst_n)
      wrMisc |=> termOffAtDetect == $past(regReq.data[7])
      && complianceDetectOff == $past(regReq.data[0]))
      else $error("misc controls not updated");

   a_lp_off_write: assert property (@(posedge clk) disable iff (!rst_n)
      wrMisc
      |=> lowPowerDetectOff == $past(regReq.data[4]))
      else $error("sleep detect control not updated");

   a_misc_read: assert property (@(posedge clk) disable iff (!rst_n)
      regReq.rdEn && regReq.addr == ADDR_MISC
      |=> regRdData == $past(misc_q))
      else $error("misc read wrong");

   a_sleep_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      misc_q.lowPowerOff && link[0].inSleep && !link[0].inUnplugged
      |=> !detectPulse[0])
      else $error("detect tick while suppressed");

   a_tick_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
      !link[0].inUnplugged && !link[0].inSleep
      |=> !detectPulse[0])
      else $error("detect tick outside detect states");

   a_tick_single: assert property (@(posedge clk) disable iff (!rst_n)
      detectPulse[0]
      |=> !detectPulse[0])
      else $error("detect tick longer than one cycle");

   a_skip_warm: assert property (@(posedge clk) disable iff (!rst_n)
      link[1].warmPollSeen
      |=> skipDetect[1] == $past(misc_q.skipAfterWarm))
      else $error("warm reset skip wrong");

   a_skip_clear: assert property (@(posedge clk) disable iff (!rst_n)
      !link[0].warmPollSeen
      |=> !skipDetect[0])
      else $error("warm reset skip without polling");

   a_long_gated: assert property (@(posedge clk) disable iff (!rst_n)
      !aeqFast ##1 !aeqFast
      |-> !portStat[0].longChannel)
      else $error("long channel flag without fast EQ");

   a_long_set: assert property (@(posedge clk) disable iff (!rst_n)
      aeqFast && link[0].longChannel
      |=> portStat[0].longChannel)
      else $error("long channel flag missing");

   a_dual_lane: assert property (@(posedge clk) disable iff (!rst_n)
      link[1].dualLane
      |=> portStat[1].dualLane)
      else $error("dual lane flag missing");

   a_dual_clear: assert property (@(posedge clk) disable iff (!rst_n)
      !link[1].dualLane
      |=> !portStat[1].dualLane)
      else $error("dual lane flag stuck");

   a_compliance: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(link[1].inCompliance)
      |=> !portStat[1].compliance)
      else $error("compliance flag stuck");

   a_compliance_set: assert property (@(posedge clk) disable iff (!rst_n)
      link[1].inCompliance
      |=> portStat[1].compliance)
      else $error("compliance flag missing");

   a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(link[1].inSleep)
      |=> portStat[1].sleepState)
      else $error("sleep flag not set on entry");

   a_first_sleep: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(link[0].inSleep)
      |=> portStat[0].sleepState)
      else $error("port one sleep flag not set on entry");

   a_unplug_entry: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(link[0].inUnplugged)
      |=> portStat[0].unplugged)
      else $error("unplugged flag not set on entry");

   a_stat1_read: assert property (@(posedge clk) disable iff (!rst_n)
      regReq.rdEn && regReq.addr == ADDR_STAT1
      |=> regRdData == $past(portStat[0]))
      else $error("port one status read wrong");

   a_stat2_read: assert property (@(posedge clk) disable iff (!rst_n)
      regReq.rdEn && regReq.addr == ADDR_STAT2
      |=> regRdData == $past(portStat[1]))
      else $error("port two status read wrong");

   a_active_leave: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(link[0].inU0)
      |=> !portStat[0].activeState)
      else $error("active flag kept after exit");

   a_unplug_leave: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(link[0].inUnplugged)
      |=> !portStat[0].unplugged)
      else $error("unplugged flag kept after exit");

   a_one_flag: assert property (@(posedge clk) disable iff (!rst_n)
      $onehot0({link[0].inU0, link[0].inSleep, link[0].inUnplugged})
      ##1 $onehot0({link[0].inU0, link[0].inSleep, link[0].inUnplugged})
      |-> $onehot0({portStat[0].activeState, portStat[0].sleepState,
                    portStat[0].unplugged}))
      else $error("more than one power flag set");

   c_takeover_write: cover property (@(posedge clk) disable iff (!rst_n)
      wrHostEq && eqSoftwareTakeover);

   c_detect_tick: cover property (@(posedge clk) disable iff (!rst_n)
      detectPulse[0]);

   c_active_entry: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(portStat[0].activeState));

   c_sleep_tick: cover property (@(posedge clk) disable iff (!rst_n)
      detectPulse[0] && link[0].inSleep);

   c_strap_caught: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(strapCaught_q));
endmodule
